// *** hdl/sirq_pkg.sv ***
// Constants and types for the sensor interrupt and sample-queue register bank.
// Assumes one 8-bit register space reached over a two-wire serial slave.
package sirq_pkg;
	// Register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h01;
	localparam logic [7:0] OFS_WR_IDX = 8'h04;
	localparam logic [7:0] OFS_RD_IDX = 8'h05;
	localparam logic [7:0] OFS_LOST = 8'h06;
	localparam logic [7:0] OFS_FILL = 8'h07;
	localparam logic [7:0] OFS_QOUT = 8'h08;
	localparam logic [7:0] OFS_LEVEL = 8'h09;
	localparam logic [7:0] OFS_QCTRL = 8'h0a;
	localparam logic [7:0] OFS_SRST = 8'h0c;
	localparam logic [7:0] OFS_HI_UPPER = 8'h10;
	localparam logic [7:0] OFS_HI_LOWER = 8'h11;
	// Field positions
	localparam int BIT_AF = 7;
	localparam int BIT_LO = 2;
	localparam int BIT_HI = 1;
	localparam int BIT_DONE = 0;
	localparam int BIT_FLUSH = 4;
	localparam int BIT_POP_CLR = 3;
	localparam int BIT_AF_STYLE = 2;
	localparam int BIT_ROLL = 1;
	localparam int BIT_SRST = 0;
	localparam logic [7:0] IRQ_MASK_BITS = 8'h87;
	localparam logic [7:0] QCTRL_BITS = 8'h1e;
	// Values after reset, then the low alarm limit and the lost-count ceiling
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_QCTRL = 8'h00;
	localparam logic [4:0] RST_LEVEL = 5'h0f;
	localparam logic [7:0] RST_HI_UPPER = 8'h7f;
	localparam logic [7:0] RST_HI_LOWER = 8'hff;
	localparam logic [15:0] LOW_LIMIT = 16'h8000;
	localparam logic [4:0] LOST_MAX = 5'h1f;
	// Serial slave address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h48;
	// Sample queue shape
	localparam int QUEUE_WIDTH = 16;
	localparam int QUEUE_DEPTH = 16;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_AACK = 3'b010,
		I2C_PTR = 3'b011,
		I2C_WACK = 3'b100,
		I2C_WDAT = 3'b101,
		I2C_RDAT = 3'b110,
		I2C_RACK = 3'b111
	} sirq_i2c_t;
endpackage : sirq_pkg

// *** hdl/sirq_regs.sv ***
// Sample queue and register bank of the temperature sensor, with its serial slave.
// Assumes samples arrive on their own clock, spaced at least four bank clocks apart.

module sirq_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	assign in_ready = cnt_ff != (AW+1)'(DEPTH);
	assign out_valid = cnt_ff != '0;
	assign out_data = mem_ff[rp_ff];
	assign count = cnt_ff;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_ff[wp_ff] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= rp_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sirq_fifo

// Functional notes
// [R01] Almost-full flag drives pin when bit7 set
// [R02] Low-alarm flag drives pin when bit2 set
// [R03] High-alarm flag drives pin when bit1 set
// [R04] Conversion-done flag drives pin when bit0 set
// [R05] Write index read-only at 0x04, reset zero
// [R06] Read index at 0x05, host and device update
// [R07] Lost-sample count read-only at 0x06
// [R08] Queued count five bits at 0x07
// [R09] Almost-full level at 0x09, resets 0x0F
// [R10] Queue control bits 4..1 at 0x0A
// [R11] Soft reset restores defaults, self-clearing
// [R12] Upper threshold byte joins lower byte
// [R13] High threshold resets to 0x7FFF
// [R14] Enabled set flag asserts interrupt pin
// [R15] Sample above threshold sets high alarm
// [R16] Almost-full cleared by status or pop read
// [R17] Pin is OR of masked flags
// [R18] Queue output byte read-only at 0x08
module sirq_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial register port, open drain
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	// Interrupt pin, open drain
	input wire logic int_pin_is_irq,
	output logic int_pin_o,
	output logic int_pin_oe_n,
	// Sample source on its own clock
	input wire logic sample_clock,
	input wire logic sample_valid,
	input wire logic [sirq_pkg::QUEUE_WIDTH-1:0] sample_data
);
	import sirq_pkg::*;

	// Sample source domain: hold word, toggle per sample
	logic [15:0] hold_ff;
	logic tgl_ff;
	always_ff @(posedge sample_clock or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff <= 16'h0000;
			tgl_ff <= 1'b0;
		end else if (sample_valid) begin
			hold_ff <= sample_data;
			tgl_ff <= ~tgl_ff;
		end
	end

	// Synchronisers
	logic tg_s1_ff, tg_s2_ff, tg_s3_ff;
	logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
	logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
	logic mode_s1_ff, mode_s2_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{tg_s1_ff, tg_s2_ff, tg_s3_ff} <= 3'h0;
			{scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
			{sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
			{mode_s1_ff, mode_s2_ff} <= 2'h0;
		end else begin
			{tg_s1_ff, tg_s2_ff, tg_s3_ff} <= {tgl_ff, tg_s1_ff, tg_s2_ff};
			{scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {scl_i, scl_s1_ff, scl_s2_ff};
			{sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {sda_i, sda_s1_ff, sda_s2_ff};
			{mode_s1_ff, mode_s2_ff} <= {int_pin_is_irq, mode_s1_ff};
		end
	end

	logic evt, scl_rise, scl_fall, start, stop;
	assign evt = tg_s2_ff ^ tg_s3_ff;
	assign scl_rise = scl_s2_ff & ~scl_s3_ff;
	assign scl_fall = ~scl_s2_ff & scl_s3_ff;
	assign start = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
	assign stop = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

	// Serial slave
	sirq_i2c_t st_ff;
	logic [2:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [7:0] ptr_ff;
	logic rnw_ff, nack_ff, sda_oe_n_ff, bit_seen_ff;
	logic [7:0] rd_byte;
	logic wr_en, rd_en, srst;
	assign wr_en = scl_fall && st_ff == I2C_WDAT && cnt_ff == 3'h0;
	assign rd_en = scl_fall && ((st_ff == I2C_AACK && rnw_ff) || (st_ff == I2C_RACK && !nack_ff));
	assign srst = wr_en && ptr_ff == OFS_SRST && sh_ff[BIT_SRST]; // R11
	assign sda_o = 1'b0;
	assign sda_oe_n = sda_oe_n_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= I2C_IDLE;
			cnt_ff <= 3'h0;
			sh_ff <= 8'h00;
			ptr_ff <= 8'h00;
			rnw_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_oe_n_ff <= 1'b1;
			bit_seen_ff <= 1'b0;
		end else if (start) begin
			st_ff <= I2C_ADDR;
			cnt_ff <= 3'h0;
			sda_oe_n_ff <= 1'b1;
			bit_seen_ff <= 1'b0;
		end else if (stop) begin
			st_ff <= I2C_IDLE;
			sda_oe_n_ff <= 1'b1;
		end else if (scl_rise) begin
			case (st_ff)
				I2C_ADDR, I2C_PTR, I2C_WDAT: begin
					sh_ff <= {sh_ff[6:0], sda_s2_ff};
					cnt_ff <= cnt_ff + 3'h1;
					bit_seen_ff <= 1'b1;
				end
				I2C_RDAT: cnt_ff <= cnt_ff + 3'h1;
				I2C_RACK: nack_ff <= sda_s2_ff;
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (st_ff)
				// The clock fall that closes START carries no address bit yet
				I2C_ADDR: if (cnt_ff == 3'h0 && bit_seen_ff) begin
					if (sh_ff[7:1] == DEV_ADDR) begin
						st_ff <= I2C_AACK;
						rnw_ff <= sh_ff[0];
						sda_oe_n_ff <= 1'b0;
					end else begin
						st_ff <= I2C_IDLE;
					end
				end
				I2C_PTR: if (cnt_ff == 3'h0) begin
					ptr_ff <= sh_ff;
					st_ff <= I2C_WACK;
					sda_oe_n_ff <= 1'b0;
				end
				I2C_WACK: begin
					st_ff <= I2C_WDAT;
					sda_oe_n_ff <= 1'b1;
				end
				I2C_WDAT: if (cnt_ff == 3'h0) begin
					ptr_ff <= ptr_ff + 8'h01;
					st_ff <= I2C_WACK;
					sda_oe_n_ff <= 1'b0;
				end
				I2C_RDAT: if (cnt_ff == 3'h0) begin
					st_ff <= I2C_RACK;
					sda_oe_n_ff <= 1'b1;
				end else begin
					sh_ff <= {sh_ff[6:0], 1'b0};
					sda_oe_n_ff <= sh_ff[6];
				end
				I2C_AACK, I2C_RACK: if (rd_en) begin
					st_ff <= I2C_RDAT;
					sh_ff <= rd_byte;
					sda_oe_n_ff <= rd_byte[7];
					ptr_ff <= ptr_ff + 8'h01;
				end else if (st_ff == I2C_AACK) begin
					st_ff <= I2C_PTR;
					sda_oe_n_ff <= 1'b1;
				end else begin
					st_ff <= I2C_IDLE;
				end
				default: st_ff <= I2C_IDLE;
			endcase
		end
	end

	// Register bank
	logic [7:0] mask_ff, flags_ff, qctrl_ff, hi_up_ff, hi_lo_ff;
	logic [4:0] level_ff, wr_idx_ff, rd_idx_ff, lost_ff;
	logic phase_ff, pend_v_ff;
	logic [15:0] pend_d_ff;
	logic in_ready, out_valid, push, pop, roll_drop, lost_drop, flush;
	logic [15:0] head;
	logic [4:0] fill;
	logic [5:0] fill_nxt;
	logic [7:0] q_byte, set_v, clr_v;
	logic qout_rd, wr_w;

	assign wr_w = wr_en && !srst;
	assign flush = srst || (wr_en && ptr_ff == OFS_QCTRL && sh_ff[BIT_FLUSH]); // R10
	assign push = pend_v_ff && in_ready;
	assign roll_drop = pend_v_ff && !in_ready && qctrl_ff[BIT_ROLL]; // R10
	assign lost_drop = pend_v_ff && !in_ready && !qctrl_ff[BIT_ROLL];
	assign qout_rd = rd_en && ptr_ff == OFS_QOUT && out_valid;
	// The queue word is read upper byte first; the lower byte read pops it
	assign pop = roll_drop || (qout_rd && phase_ff);
	assign q_byte = out_valid ? (phase_ff ? head[7:0] : head[15:8]) : 8'h00; // R18
	assign fill_nxt = {1'b0, fill} + 6'h01;

	sirq_fifo #(
		.WIDTH(QUEUE_WIDTH),
		.DEPTH(QUEUE_DEPTH)
	) u_queue (
		.clock(clock),
		.rst_n(rst_n),
		.flush(flush),
		.in_valid(pend_v_ff),
		.in_ready(in_ready),
		.in_data(pend_d_ff),
		.out_valid(out_valid),
		.out_ready(pop),
		.out_data(head),
		.count(fill)
	);

	always_comb begin
		case (ptr_ff)
			OFS_STATUS: rd_byte = flags_ff & IRQ_MASK_BITS; // R17
			OFS_IRQ_MASK: rd_byte = mask_ff;
			OFS_WR_IDX: rd_byte = {3'h0, wr_idx_ff}; // R05
			OFS_RD_IDX: rd_byte = {3'h0, rd_idx_ff}; // R06
			OFS_LOST: rd_byte = {3'h0, lost_ff}; // R07
			OFS_FILL: rd_byte = {2'h0, 1'b0, fill}; // R08
			OFS_QOUT: rd_byte = q_byte;
			OFS_LEVEL: rd_byte = {3'h0, level_ff}; // R09
			OFS_QCTRL: rd_byte = qctrl_ff;
			OFS_HI_UPPER: rd_byte = hi_up_ff;
			OFS_HI_LOWER: rd_byte = hi_lo_ff;
			default: rd_byte = 8'h00;
		endcase
	end

	// Configuration registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_ff <= RST_IRQ_MASK;
			level_ff <= RST_LEVEL;
			qctrl_ff <= RST_QCTRL;
			hi_up_ff <= RST_HI_UPPER;
			hi_lo_ff <= RST_HI_LOWER;
		end else if (srst) begin // R11
			mask_ff <= RST_IRQ_MASK;
			level_ff <= RST_LEVEL;
			qctrl_ff <= RST_QCTRL;
			hi_up_ff <= RST_HI_UPPER; // R13
			hi_lo_ff <= RST_HI_LOWER;
		end else if (wr_w) begin
			case (ptr_ff)
				OFS_IRQ_MASK: mask_ff <= sh_ff & IRQ_MASK_BITS;
				OFS_LEVEL: level_ff <= sh_ff[4:0]; // R09
				OFS_QCTRL: qctrl_ff <= sh_ff & QCTRL_BITS; // R10
				OFS_HI_UPPER: hi_up_ff <= sh_ff; // R12
				OFS_HI_LOWER: hi_lo_ff <= sh_ff;
				default: begin
				end
			endcase
		end
	end

	// Queue indices and counters; host writes to the write index are ignored
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_idx_ff <= 5'h00;
			rd_idx_ff <= 5'h00;
			lost_ff <= 5'h00;
			phase_ff <= 1'b0;
		end else if (flush) begin
			wr_idx_ff <= 5'h00;
			rd_idx_ff <= 5'h00;
			lost_ff <= 5'h00;
			phase_ff <= 1'b0;
		end else begin
			if (push) begin
				wr_idx_ff <= wr_idx_ff + 5'h01; // R05
			end
			if (wr_w && ptr_ff == OFS_RD_IDX) begin
				rd_idx_ff <= sh_ff[4:0]; // R06
			end else if (pop) begin
				rd_idx_ff <= rd_idx_ff + 5'h01; // R06
			end
			if (lost_drop && lost_ff != LOST_MAX) begin
				lost_ff <= lost_ff + 5'h01; // R07
			end
			if (roll_drop) begin
				phase_ff <= 1'b0;
			end else if (qout_rd) begin
				phase_ff <= ~phase_ff;
			end
		end
	end

	// Pending sample waits here while the queue is full and roll is set; with roll clear a full queue drops it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_v_ff <= 1'b0;
			pend_d_ff <= 16'h0000;
		end else if (evt) begin
			pend_v_ff <= 1'b1;
			pend_d_ff <= hold_ff;
		end else if (flush || push || lost_drop) begin
			pend_v_ff <= 1'b0;
		end
	end

	// Status flags: a set in the same cycle as a clear wins
	always_comb begin
		set_v = 8'h00;
		clr_v = 8'h00;
		if (evt) begin
			set_v[BIT_DONE] = 1'b1;
			set_v[BIT_HI] = $signed(hold_ff) > $signed({hi_up_ff, hi_lo_ff}); // R15 R12
			set_v[BIT_LO] = $signed(hold_ff) < $signed(LOW_LIMIT);
		end
		if (push && (qctrl_ff[BIT_AF_STYLE] ? fill_nxt >= {1'b0, level_ff} : fill_nxt == {1'b0, level_ff})) begin
			set_v[BIT_AF] = 1'b1;
		end
		if (rd_en && ptr_ff == OFS_STATUS) begin
			clr_v = IRQ_MASK_BITS; // R16
		end
		if (qout_rd && qctrl_ff[BIT_POP_CLR]) begin
			clr_v[BIT_AF] = 1'b1; // R16
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= 8'h00;
		end else if (srst) begin
			flags_ff <= 8'h00;
		end else begin
			flags_ff <= (flags_ff & ~clr_v) | set_v;
		end
	end

	// Interrupt pin pulls low while int_pin_is_irq is high and any enabled flag is set
	logic irq_oe_n_ff;
	assign int_pin_o = 1'b0;
	assign int_pin_oe_n = irq_oe_n_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_oe_n_ff <= 1'b1;
		end else begin
			irq_oe_n_ff <= !(mode_s2_ff && |(flags_ff & mask_ff)); // R01 R02 R03 R04 R14 R17
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_af_irq_drive: assert property (mode_s2_ff && flags_ff[7] && mask_ff[7] |=> !int_pin_oe_n) // R01
		else $error("almost-full did not drive pin");
	a_lo_irq_drive: assert property (mode_s2_ff && flags_ff[2] && mask_ff[2] |=> !int_pin_oe_n) // R02
		else $error("low alarm did not drive pin");
	a_hi_irq_drive: assert property (mode_s2_ff && flags_ff[1] && mask_ff[1] |=> !int_pin_oe_n) // R03
		else $error("high alarm did not drive pin");
	a_done_irq_drive: assert property (mode_s2_ff && flags_ff[0] && mask_ff[0] |=> !int_pin_oe_n) // R04
		else $error("done flag did not drive pin");
	a_irq_masked_off: assert property (!(mode_s2_ff && |(flags_ff & mask_ff)) |=> int_pin_oe_n) // R14
		else $error("pin driven with no enabled flag");
	a_wr_index_ro: assert property (wr_en && ptr_ff == OFS_WR_IDX && !push && !flush |=> $stable(wr_idx_ff)) // R05
		else $error("host write changed write index");
	a_fill_bound: assert property (fill <= 5'h10) // R08
		else $error("queue count above depth");
	a_soft_rst_dflt: assert property (srst |=> mask_ff == 8'h00 && level_ff == 5'h0f && flags_ff == 8'h00) // R11
		else $error("soft reset left settings");
	a_hi_thr_dflt: assert property (srst |=> {hi_up_ff, hi_lo_ff} == 16'h7fff) // R13
		else $error("threshold not restored");
	a_status_rd_clr: assert property (rd_en && ptr_ff == OFS_STATUS && !push ##1 !evt |-> !flags_ff[7]) // R16
		else $error("status read kept almost-full");

	c_sample_in: cover property (evt ##[1:4] push);
	c_roll_drop: cover property (roll_drop);
	c_irq_active: cover property (!int_pin_oe_n);
	c_status_read: cover property (rd_en && ptr_ff == OFS_STATUS);
endmodule : sirq_regs

// *** sim/sirq_host.sv ***
// Two-wire serial host that reaches the register bank through its serial port.
// Assumes a pull-up on the data line, resolved by the bench, and paces itself on the bank clock.
module sirq_host (
	// Pacing clock
	input wire logic clock,
	// Serial lines
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HP = 6;
	int nacks = 0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	// Data moves only two clocks after a fall, so the slave never sees it change while the clock is high
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		tick(HP);
		scl = 1'b1;
		tick(HP);
		r = sda;
		scl = 1'b0;
		tick(2);
	endtask : bit_io
	task automatic xfer(input logic [7:0] tx, input logic rd_byte, output logic [7:0] rx);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(1'b1, r);
		if (!rd_byte && r)
			nacks++;
	endtask : xfer
	task automatic start;
		sda_low = 1'b0;
		scl = 1'b1;
		tick(HP);
		sda_low = 1'b1;
		tick(HP);
		scl = 1'b0;
		tick(2);
	endtask : start
	task automatic stop;
		sda_low = 1'b1;
		tick(HP);
		scl = 1'b1;
		tick(HP);
		sda_low = 1'b0;
		tick(HP);
	endtask : stop
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [7:0] x;
		start;
		xfer({sirq_pkg::DEV_ADDR, 1'b0}, 1'b0, x);
		xfer(ofs, 1'b0, x);
		xfer(d, 1'b0, x);
		stop;
	endtask : wr
	// Single-byte reads only, closed by a NACK
	task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
		logic [7:0] x;
		start;
		xfer({sirq_pkg::DEV_ADDR, 1'b0}, 1'b0, x);
		xfer(ofs, 1'b0, x);
		stop;
		start;
		xfer({sirq_pkg::DEV_ADDR, 1'b1}, 1'b0, x);
		xfer(8'hff, 1'b1, d);
		stop;
	endtask : rd
	// Two-byte burst: the first byte is acknowledged so the slave moves to the next offset
	task automatic rd2(input logic [7:0] ofs, output logic [15:0] d);
		logic [7:0] x;
		logic r;
		start;
		xfer({sirq_pkg::DEV_ADDR, 1'b0}, 1'b0, x);
		xfer(ofs, 1'b0, x);
		stop;
		start;
		xfer({sirq_pkg::DEV_ADDR, 1'b1}, 1'b0, x);
		for (int i = 15; i >= 8; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(1'b0, r);
		xfer(8'hff, 1'b1, x);
		d[7:0] = x;
		stop;
	endtask : rd2
endmodule : sirq_host

// *** sim/sirq_regs_tb.sv ***
// Self-checking bench of the sensor register bank with an integer reference model.
// Assumes the design package and the serial host model are compiled first.
module sirq_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sirq_pkg::*;
	logic clock, rst_n, scl, sda_low, int_pin_is_irq, sample_clock, sample_valid;
	logic [15:0] sample_data, rd_word;
	logic sda_o, sda_oe_n, int_pin_o, int_pin_oe_n;
	logic [7:0] tbl[10];
	int error_cnt = 0;
	int checks_done = 0;
	int seed = 13754;
	int mask, level, qctrl, thr, lost, af, hi, done, rdp, wrp;
	int bits[4] = '{8'h80, 8'h04, 8'h02, 8'h01};
	int q[$];
	// Pull-up on the shared data line
	wire sda_line = !(sda_low || !sda_oe_n);

	sirq_regs uut (.clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .int_pin_is_irq(int_pin_is_irq), .int_pin_o(int_pin_o),
		.int_pin_oe_n(int_pin_oe_n), .sample_clock(sample_clock), .sample_valid(sample_valid),
		.sample_data(sample_data));
	sirq_host u_host (.clock(clock), .sda(sda_line), .scl(scl), .sda_low(sda_low));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		sample_clock = 1'b0;
		#1.3;
		forever #3 sample_clock = ~sample_clock;
	end
	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		end_sim();
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic defaults;
		mask = 0;
		level = 15;
		qctrl = 0;
		thr = 16'h7fff;
		lost = 0;
		af = 0;
		hi = 0;
		done = 0;
		rdp = 0;
		wrp = 0;
		q.delete();
	endtask : defaults
	function automatic logic [7:0] exp_reg(input logic [7:0] ofs);
		case (ofs)
			OFS_IRQ_MASK: return 8'(mask);
			OFS_WR_IDX: return 8'(wrp % 32);
			OFS_RD_IDX: return 8'(rdp % 32);
			OFS_LOST: return 8'(lost);
			OFS_FILL: return 8'(q.size());
			OFS_LEVEL: return 8'(level);
			OFS_QCTRL: return 8'(qctrl);
			OFS_HI_UPPER: return 8'(thr >> 8);
			OFS_HI_LOWER: return 8'(thr);
			default: return 8'h00;
		endcase
	endfunction : exp_reg
	task automatic wrm(input logic [7:0] ofs, input int x);
		u_host.wr(ofs, 8'(x));
		case (ofs)
			OFS_IRQ_MASK: mask = x & IRQ_MASK_BITS;
			OFS_RD_IDX: rdp = x & 31;
			OFS_LEVEL: level = x & 31;
			OFS_QCTRL: qctrl = x & QCTRL_BITS;
			OFS_HI_UPPER: thr = {x[7:0], thr[7:0]};
			OFS_HI_LOWER: thr = {thr[15:8], x[7:0]};
			OFS_SRST: if (x[0]) defaults();
			default: ;
		endcase
		if (ofs == OFS_QCTRL && x[BIT_FLUSH]) begin
			q.delete();
			rdp = 0;
			wrp = 0;
			lost = 0;
		end
	endtask : wrm
	task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		u_host.rd(ofs, d);
		chk(d, exp);
	endtask : rchk
	task automatic check_all;
		foreach (tbl[i]) rchk(tbl[i], exp_reg(tbl[i]));
	endtask : check_all
	task automatic stchk;
		rchk(OFS_STATUS, {af[0], 5'h00, hi[0], done[0]});
		af = 0;
		hi = 0;
		done = 0;
	endtask : stchk
	task automatic pin_chk;
		chk(int_pin_oe_n, !(int_pin_is_irq && ({af[0], 5'h00, hi[0], done[0]} & mask[7:0]) != 0));
	endtask : pin_chk
	// Spacing of four sample clocks keeps samples at least four bank clocks apart
	task automatic push(input logic [15:0] s);
		@(negedge sample_clock);
		sample_data = s;
		sample_valid = 1'b1;
		@(negedge sample_clock);
		sample_valid = 1'b0;
		repeat (4) @(negedge sample_clock);
		repeat (8) @(negedge clock);
		done = 1;
		if ($signed(s) > $signed(16'(thr)))
			hi = 1;
		if (q.size() == 16 && !qctrl[BIT_ROLL]) begin
			if (lost < 31)
				lost++;
		end else begin
			if (q.size() == 16) begin
				void'(q.pop_front());
				rdp++;
			end
			q.push_back(s);
			wrp++;
			if (qctrl[BIT_AF_STYLE] ? q.size() >= level : q.size() == level)
				af = 1;
		end
	endtask : push
	task automatic qpop;
		rchk(OFS_QOUT, 8'(q[0] >> 8));
		rchk(OFS_QOUT, 8'(q[0]));
		void'(q.pop_front());
		rdp++;
		if (qctrl[BIT_POP_CLR])
			af = 0;
	endtask : qpop

	initial begin
		rst_n = 1'b0;
		sample_valid = 1'b0;
		sample_data = 16'h0000;
		int_pin_is_irq = 1'b1;
		tbl = '{OFS_IRQ_MASK, OFS_WR_IDX, OFS_RD_IDX, OFS_LOST, OFS_FILL, OFS_LEVEL, OFS_QCTRL,
			OFS_HI_UPPER, OFS_HI_LOWER, 8'h0b};
		defaults();
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		repeat (5) @(negedge clock);
		check_all();
		rchk(OFS_QOUT, 8'h00);
		pin_chk();
		// Flush stays out of the random writes so the queue is left alone
		foreach (tbl[i]) begin
			if (tbl[i] != OFS_RD_IDX)
				wrm(tbl[i], $random(seed) & (tbl[i] == OFS_QCTRL ? 8'hef : 8'hff));
		end
		check_all();
		wrm(OFS_QCTRL, 0);
		wrm(OFS_LEVEL, 3);
		wrm(OFS_IRQ_MASK, 0);
		wrm(OFS_HI_UPPER, 8'h01);
		wrm(OFS_HI_LOWER, 8'h00);
		u_host.rd2(OFS_HI_UPPER, rd_word);
		chk(rd_word, 16'(thr));
		push(16'($random(seed) & 16'h00ff));
		push(16'(16'h0101 + ($random(seed) & 16'h00ff)));
		push(16'h0100);
		pin_chk();
		foreach (bits[i]) begin
			wrm(OFS_IRQ_MASK, bits[i]);
			pin_chk();
		end
		int_pin_is_irq = 1'b0;
		repeat (4) @(negedge clock);
		pin_chk();
		int_pin_is_irq = 1'b1;
		check_all();
		stchk();
		wrm(OFS_IRQ_MASK, 8'h80);
		wrm(OFS_QCTRL, 8'h0c);
		push(16'($random(seed)));
		pin_chk();
		qpop();
		pin_chk();
		check_all();
		wrm(OFS_QCTRL, 8'h10);
		check_all();
		wrm(OFS_QCTRL, 0);
		repeat (17) push(16'($random(seed)));
		rchk(OFS_LOST, 8'(lost));
		rchk(OFS_FILL, 8'(q.size()));
		wrm(OFS_QCTRL, 8'h02);
		push(16'($random(seed)));
		qpop();
		stchk();
		wrm(OFS_RD_IDX, 8'h0a);
		rchk(OFS_RD_IDX, 8'h0a);
		wrm(OFS_SRST, 1);
		check_all();
		stchk();
		pin_chk();
		chk({sda_o, int_pin_o}, 16'h0000);
		chk(16'(u_host.nacks), 16'h0000);
		end_sim();
	end
endmodule : sirq_regs_tb
